// ===== mode_setup_pkg.sv
// Package: setup layouts, register map and link constants for the setup selector
`default_nettype none
package mode_setup_pkg;
  localparam int CHANNELS = 15;
  // Link baud codes and parity codes
  localparam logic [3:0] BAUD_300 = 4'h0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  // Shipped stored setup
  localparam logic [7:0] ADDR_FACTORY = 8'h31;
  localparam logic [3:0] DELAY_FACTORY = 4'h2;
  localparam logic [CHANNELS-1:0] DIR_FACTORY = 15'h0000;
  // Characters
  localparam logic [7:0] CH_NULL = 8'h00;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_OK = 8'h2A;
  localparam logic [7:0] CH_ERR = 8'h3F;
  // Register byte offsets
  localparam logic [3:0] OFS_SETUP = 4'h0;
  localparam logic [3:0] OFS_DIR = 4'h4;
  localparam logic [3:0] OFS_OUT = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Stored setup, packed into the low 20 bits of the setup word
  typedef struct packed {
    logic [3:0] delay;
    logic echo;
    logic linefeed;
    logic [1:0] parity;
    logic [3:0] baud;
    logic [7:0] addr;
  } setup_t;
  localparam setup_t SETUP_FACTORY = '{delay: DELAY_FACTORY, echo: 1'b0, linefeed: 1'b0,
                                      parity: PAR_NONE, baud: BAUD_300, addr: ADDR_FACTORY};
  typedef struct packed {
    logic [3:0] baud;
    logic [1:0] parity;
  } link_cfg_t;
  localparam link_cfg_t LINK_DEFAULT = '{baud: BAUD_300, parity: PAR_NONE};
  typedef enum logic [1:0] {
    CMD_OTHER = 2'b00,
    CMD_READ_SETUP = 2'b01,
    CMD_SETUP_WRITE = 2'b10,
    CMD_INPUT_QUERY = 2'b11
  } cmd_kind_t;
  typedef struct packed {
    cmd_kind_t kind;
    logic err;
    logic [7:0] addr;
    logic [31:0] data;
  } cmd_t;
  typedef struct packed {
    logic [7:0] prompt;
    logic [7:0] addr;
    logic [31:0] data;
  } reply_t;
endpackage
`default_nettype wire

// ===== default_mode_setup_select.sv
// Setup selector: default-mode override, stored setup, channel directions, AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`default_nettype none
module default_mode_setup_select
  import mode_setup_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Fallback pin
  input wire logic default_n,
  // Decoded commands from the serial front end
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  // Reply header to the serial front end
  output logic reply_valid,
  output reply_t reply,
  // Active link setup
  output link_cfg_t link_cfg,
  output logic default_active,
  output logic prog_reset,
  // Channel pins
  input wire logic [CHANNELS-1:0] chan_in,
  output logic [CHANNELS-1:0] chan_out,
  output logic [CHANNELS-1:0] chan_oe_n
);

  function automatic logic legal_addr(input logic [7:0] c);
    return !(c == CH_NULL || c == CH_CR || c == CH_DOLLAR || c == CH_HASH);
  endfunction

  function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic dflt_meta_r, dflt_sync_r, dflt_prev_r;
  logic [CHANNELS-1:0] in_meta_r, in_sync_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dflt_meta_r <= 1'b1;
      dflt_sync_r <= 1'b1;
      dflt_prev_r <= 1'b1;
      in_meta_r <= '0;
      in_sync_r <= '0;
    end else begin
      dflt_meta_r <= default_n;
      dflt_sync_r <= dflt_meta_r;
      dflt_prev_r <= dflt_sync_r;
      in_meta_r <= chan_in;
      in_sync_r <= in_meta_r;
    end
  end

  assign default_active = !dflt_sync_r;
  assign prog_reset = dflt_sync_r && !dflt_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic aw_full_r, w_full_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;

  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;
  assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_full_r <= 1'b0;
    end
  end

  logic wr_mapped;
  assign wr_mapped = aw_addr_r == OFS_SETUP || aw_addr_r == OFS_DIR || aw_addr_r == OFS_OUT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored setup and channel configuration (nonvolatile image)

  setup_t setup_r;
  logic [CHANNELS-1:0] dir_r, out_r, dir_act_r;
  logic cmd_hit, cmd_wr;
  logic [31:0] setup_merged, dir_merged, out_merged;

  // Byte lanes merged against the current value; unused upper bits read back as zero
  assign setup_merged = strobe_merge(32'(setup_r), w_data_r, w_strb_r);
  assign dir_merged = strobe_merge(32'(dir_r), w_data_r, w_strb_r);
  assign out_merged = strobe_merge(32'(out_r), w_data_r, w_strb_r);

  // Link setup write lands after a bus write in the same cycle, so it wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_r <= SETUP_FACTORY;
    end else if (cmd_wr) begin
      setup_r <= setup_t'(cmd.data[$bits(setup_t)-1:0]);
    end else if (wr_go && aw_addr_r == OFS_SETUP) begin
      setup_r <= setup_t'(setup_merged[$bits(setup_t)-1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_r <= DIR_FACTORY;
      out_r <= '0;
    end else if (wr_go) begin
      if (aw_addr_r == OFS_DIR) begin
        dir_r <= dir_merged[CHANNELS-1:0];
      end
      if (aw_addr_r == OFS_OUT) begin
        out_r <= out_merged[CHANNELS-1:0];
      end
    end
  end

  // Stored directions reach the pins only at reset or program reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_act_r <= DIR_FACTORY;
    end else if (prog_reset) begin
      dir_act_r <= dir_r;
    end
  end

  assign chan_out = out_r;
  assign chan_oe_n = ~dir_act_r;

  ////////////////////////////////////////////////////////////////////////////
  // Active link setup

  link_cfg_t link_r;

  // Stored values reach the link only on program reset, so a write cannot drop the host mid-session
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_r <= LINK_DEFAULT;
    end else if (default_active) begin
      link_r <= LINK_DEFAULT;
    end else if (prog_reset) begin
      link_r <= '{baud: setup_r.baud, parity: setup_r.parity};
    end
  end

  assign link_cfg = link_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command answering

  assign cmd_hit = cmd_valid && (default_active ? legal_addr(cmd.addr) : cmd.addr == setup_r.addr);
  assign cmd_wr = cmd_hit && !cmd.err && cmd.kind == CMD_SETUP_WRITE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reply_valid <= 1'b0;
      reply <= '0;
    end else begin
      reply_valid <= cmd_hit;
      if (cmd_hit) begin
        reply.addr <= setup_r.addr;
        reply.prompt <= cmd.err ? CH_ERR : CH_OK;
        reply.data <= '0;
        if (!cmd.err) begin
          unique case (cmd.kind)
            CMD_READ_SETUP: reply.data <= 32'(setup_r);
            CMD_INPUT_QUERY: reply.data <= 32'(in_sync_r);
            CMD_SETUP_WRITE: reply.data <= '0;
            CMD_OTHER: reply.data <= '0;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_SETUP: s_axi_rdata <= 32'(setup_r);
        OFS_DIR: s_axi_rdata <= 32'(dir_r);
        OFS_OUT: s_axi_rdata <= 32'(out_r);
        OFS_STATUS: s_axi_rdata <= 32'({default_active, link_r});
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_default_link: assert property (default_active |=> link_cfg == LINK_DEFAULT)
    else $error("Default mode link not at 300 baud no parity");
  chk_pin_enters: assert property ($fell(default_n) ##1 !default_n |=> default_active)
    else $error("Grounded pin did not enter default mode");
  chk_setup_kept: assert property ($rose(default_active) |-> $stable(setup_r))
    else $error("Entering default mode changed stored setup");
  chk_all_answered: assert property (cmd_valid && default_active && legal_addr(cmd.addr) |=> reply_valid)
    else $error("Default-mode command not answered");
  chk_illegal_addr: assert property (cmd_valid && default_active && !legal_addr(cmd.addr) |=> !reply_valid)
    else $error("Illegal address answered");
  chk_err_addr: assert property (cmd_hit && cmd.err
                                 |=> reply.prompt == CH_ERR && reply.addr == $past(setup_r.addr))
    else $error("Error reply without stored address");
  chk_read_setup: assert property (cmd_hit && !cmd.err && cmd.kind == CMD_READ_SETUP
                                   |=> reply.data == 32'($past(setup_r)))
    else $error("Read setup returned wrong value");
  chk_write_hold: assert property (cmd_wr && default_active ##1 default_active |=> link_cfg == LINK_DEFAULT)
    else $error("Setup write changed active link in default mode");
  chk_release_load: assert property (prog_reset |=> link_cfg.baud == $past(setup_r.baud))
    else $error("Release did not load stored baud");
  chk_release_edge: assert property ($fell(default_active) |-> prog_reset)
    else $error("No program reset on release");
  chk_query_ok: assert property (cmd_hit && !cmd.err && cmd.kind == CMD_INPUT_QUERY
                                 |=> reply.prompt == CH_OK && reply.data == 32'($past(in_sync_r)))
    else $error("Input query reply malformed");
  chk_dir_apply: assert property (prog_reset |=> chan_oe_n == ~$past(dir_r))
    else $error("Stored direction not applied");
  chk_oe_steady: assert property (!prog_reset |=> $stable(chan_oe_n))
    else $error("Channel direction changed without program reset");
  chk_reset_pulse: assert property (prog_reset |=> !prog_reset)
    else $error("Program reset longer than one cycle");
  chk_link_frozen: assert property (!prog_reset && !default_active |=> $stable(link_cfg))
    else $error("Active link changed outside program reset");
  chk_status_ro: assert property (wr_go && aw_addr_r == OFS_STATUS |=> s_axi_bresp == RESP_SLVERR)
    else $error("Status write not refused");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write response dropped before taken");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped before taken");

  cov_default_cmd: cover property (default_active && cmd_hit ##1 reply_valid);
  cov_release: cover property (default_active ##[1:20] prog_reset);
  cov_setup_wr: cover property (cmd_wr && default_active);
  cov_err_reply: cover property (reply_valid && reply.prompt == CH_ERR);
  cov_query_reply: cover property (cmd_hit && cmd.kind == CMD_INPUT_QUERY ##1 reply_valid);

endmodule
`default_nettype wire

// ===== host_cmd_model.sv
// Host model: sends one decoded command and waits out the reply window
`default_nettype none
module host_cmd_model
  import mode_setup_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Command port
  output logic cmd_valid,
  output cmd_t cmd,
  // Reply strobe
  input wire logic reply_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // Caller enters right after a rising edge
  task automatic send(input cmd_t c, output logic got);
    got = 1'b0;
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    // Released bus shows the inverse, not a stale copy
    cmd <= ~c;
    // Whole reply window passes before the next command
    repeat (8) begin
      @(posedge aclk);
      if (reply_valid === 1'b1)
        got = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ===== default_mode_setup_select_test.sv
// Bench for the setup selector: default mode, stored setup, release, registers
`default_nettype none
module default_mode_setup_select_test
  import mode_setup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, default_n;
  logic awready, wready, bvalid, arready, rvalid, reply_valid, default_active, prog_reset, cmd_valid, got;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [CHANNELS-1:0] chan_in, chan_out, chan_oe_n;
  cmd_t cmd;
  reply_t reply;
  link_cfg_t link_cfg;
  int fail_count, n_tests;
  default_mode_setup_select dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .default_n(default_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .reply_valid(reply_valid), .reply(reply), .link_cfg(link_cfg),
    .default_active(default_active), .prog_reset(prog_reset), .chan_in(chan_in), .chan_out(chan_out),
    .chan_oe_n(chan_oe_n));
  host_cmd_model host (.aclk(aclk), .cmd_valid(cmd_valid), .cmd(cmd), .reply_valid(reply_valid));
  always #4 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    r = 'x;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // The wait ends when bvalid is seen; only the watchdog ends it if no answer comes
    forever begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge aclk);
    r = 'x;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        r = rresp;
        d = rdata;
        break;
      end
    end
    rready <= 1'b0;
  endtask
  task automatic cmd_go(input cmd_kind_t k, input logic e, input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    host.send('{k, e, a, v}, got);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(link_cfg, LINK_DEFAULT);
    chk(chan_oe_n, 15'h7FFF);
    axr(OFS_SETUP);
    chk({r, d}, {RESP_OKAY, 32'h00020031});
  endtask
  task automatic t_normal();
    cmd_go(CMD_READ_SETUP, 1'b0, 8'h31, 32'h0);
    chk({got, reply}, {1'b1, CH_OK, ADDR_FACTORY, 32'h00020031});
    cmd_go(CMD_INPUT_QUERY, 1'b0, 8'h32, 32'h0);
    chk(got, 1'b0);
    cmd_go(CMD_INPUT_QUERY, 1'b0, 8'h31, 32'h0);
    chk({got, reply.prompt, reply.data}, {1'b1, CH_OK, 32'h00002A5A});
  endtask
  task automatic t_default();
    @(posedge aclk);
    default_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({default_active, link_cfg}, {1'b1, LINK_DEFAULT});
    for (int i = 0; i < 4; i++) begin
      cmd_go(CMD_READ_SETUP, 1'b0, (i == 0) ? CH_NULL : (i == 1) ? CH_CR : (i == 2) ? CH_DOLLAR : CH_HASH, 32'h0);
      chk(got, 1'b0);
    end
    cmd_go(CMD_OTHER, 1'b0, 8'h37, 32'h0);
    chk({got, reply.prompt}, {1'b1, CH_OK});
    cmd_go(CMD_OTHER, 1'b1, 8'h5A, 32'h0);
    chk({got, reply}, {1'b1, CH_ERR, ADDR_FACTORY, 32'h0});
    // Baud 5, parity 1, address kept
    cmd_go(CMD_SETUP_WRITE, 1'b0, 8'h37, 32'h00021531);
    chk({got, link_cfg}, {1'b1, LINK_DEFAULT});
    cmd_go(CMD_READ_SETUP, 1'b0, 8'h39, 32'h0);
    chk(reply, {CH_OK, ADDR_FACTORY, 32'h00021531});
    axw(OFS_DIR, 32'h00000003);
    axw(OFS_OUT, 32'h00000001);
    chk({r, chan_out}, {RESP_OKAY, 15'h0001});
    chk(chan_oe_n, 15'h7FFF);
  endtask
  task automatic t_release();
    @(posedge aclk);
    default_n <= 1'b1;
    got = 1'b0;
    repeat (6) begin
      @(posedge aclk);
      if (prog_reset === 1'b1)
        got = 1'b1;
    end
    chk(got, 1'b1);
    chk({default_active, link_cfg, chan_oe_n}, {1'b0, 6'h15, 15'h7FFC});
    cmd_go(CMD_READ_SETUP, 1'b0, 8'h37, 32'h0);
    chk(got, 1'b0);
    axr(OFS_STATUS);
    chk({r, d}, {RESP_OKAY, 32'h00000015});
    axw(OFS_STATUS, 32'h0);
    chk(r, RESP_SLVERR);
    axr(4'h2);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    @(posedge aclk);
    default_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(link_cfg, LINK_DEFAULT);
    axr(OFS_SETUP);
    chk(d, 32'h00021531);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {aclk, awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    default_n = 1'b1;
    chan_in = 15'h2A5A;
    fail_count = 0;
    n_tests = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_normal();
    t_default();
    t_release();
    final_report();
  end
  initial begin
    #200us;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
